// File: design/djp_port.sv
// debug and boundary-scan pin port: pin sharing, status, serial debug
// How it works
// - strap picks jtag or debug pin roles
// - status codes as defined, reserved never driven
// - codes 1100 to 1111 held at least two clocks
// - status follows core execution, clock synchronous
// - status pins shared with gpio by assignment
// - data nibble pins shared; gpio inputs in reset
// - data nibble shows captured data, breakpoint status
// - commands in serially, responses out serially
// - low breakpoint request halts core in debug
// - tap clocked only by tck, keeps state
// - low trst resets tap, loads bypass
// - tms high reaches reset in five edges
// - sixteen-state tap steered by tms
// - tdi shifts on rising tck into selected register
// - trst, tms, tdi read high when undriven
// - tdo shifts on falling tck, else released
module djp_port (
   // system clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // test clock
   input  wire logic        tck,
   // strap
   input  wire logic        debug_jtag_select,
   // shared jtag and debug pins
   input  wire logic        pin_trst_debug_serial_clock,
   input  wire logic        pin_tms_breakpoint_request_n,
   input  wire logic        pin_tdi_dsi,
   output logic             pin_tdo_dso_out,
   output logic             pin_tdo_dso_oe,
   // eight pads shared by status, debug data and gpio
   input  wire logic [7:0]  pad_in,
   output logic      [7:0]  pad_out,
   output logic      [7:0]  pad_oe,
   // pin assignment, one bit per pad, 1 selects debug function
   input  wire logic [7:0]  pin_assignment_reg,
   // gpio side of the core
   input  wire logic [7:0]  gpio_port_bits_out,
   input  wire logic [7:0]  gpio_port_bits_oe,
   output logic      [7:0]  gpio_port_bits_in,
   // core execution status and debug data
   input  wire logic [3:0]  core_exec_status,
   input  wire logic [3:0]  capt_data,
   input  wire logic        capt_valid,
   input  wire logic [3:0]  breakpoint_request_n_status,
   // debug module command and response words
   output logic [15:0]      dbg_cmd_data,
   output logic             dbg_cmd_valid,
   input  wire logic [15:0] dbg_resp_data,
   output logic             hw_breakpoint
);

   typedef struct packed {
      logic [1:0]  sel_s;
      logic [1:0]  debug_serial_clock_s;
      logic [1:0]  dsi_s;
      logic [1:0]  breakpoint_request_n_s;
      logic [7:0]  gpin_s1;
      logic [7:0]  gpin_s2;
      logic        debug_serial_clock_prev;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic [4:0]  bit_cnt;
      logic [15:0] cmd_data;
      logic        cmd_valid;
      logic        debug_serial_out;
      logic        hw_breakpoint_request_n;
      logic [3:0]  pst;
      logic [1:0]  pst_hold;
      logic [3:0]  ddata;
      logic [7:0]  assign_q;
   } djp_core_type;

   djp_core_type r_q;
   djp_core_type r_d;

   logic       tap_trst_n;
   logic       tap_tms;
   logic       tap_tdi;
   logic       tap_tdo;
   logic       tap_tdo_oe;
   logic       debug_serial_clock_raw;
   logic       breakpoint_request_n_raw_n;
   logic       dsi_raw;
   logic       debug_mode;
   logic       debug_serial_clock_rise;
   logic       debug_serial_clock_fall;
   logic [3:0] pst_next;
   logic [7:0] dbg_pads;

   function automatic logic pst_is_long(input logic [3:0] code);
      pst_is_long = (code[3:2] == 2'b11);
   endfunction

   function automatic logic pst_is_legal(input logic [3:0] code);
      pst_is_legal = pst_is_long(code) ||
                     ((code[3] == 1'b0) &&
                      (code != djp_pkg::PST_RSVD_2) &&
                      (code != djp_pkg::PST_RSVD_6));
   endfunction

   // pin role switch: plain gates on the strap, no state, so the tap
   // keeps working from power-up without any clk running
   always_comb begin
      // idle inputs of the unused function sit at their pullup level, except the debug serial clock, held low
      tap_trst_n = 1'b1;
      tap_tms    = 1'b1;
      tap_tdi    = 1'b1;
      debug_serial_clock_raw  = 1'b0;
      breakpoint_request_n_raw_n = 1'b1;
      dsi_raw    = 1'b1;
      if (debug_jtag_select == djp_pkg::SEL_JTAG) begin
         tap_trst_n      = pin_trst_debug_serial_clock;
         tap_tms         = pin_tms_breakpoint_request_n;
         tap_tdi         = pin_tdi_dsi;
         pin_tdo_dso_out = tap_tdo;
         pin_tdo_dso_oe  = tap_tdo_oe;
      end else begin
         debug_serial_clock_raw       = pin_trst_debug_serial_clock;
         breakpoint_request_n_raw_n      = pin_tms_breakpoint_request_n;
         dsi_raw         = pin_tdi_dsi;
         pin_tdo_dso_out = r_q.debug_serial_out;
         pin_tdo_dso_oe  = 1'b1;
      end
   end

   djp_tap i_djp_tap (
      .tck    (tck),
      .trst_n (tap_trst_n),
      .tms    (tap_tms),
      .tdi    (tap_tdi),
      .tdo    (tap_tdo),
      .tdo_oe (tap_tdo_oe),
      .pad_in (pad_in)
   );

   // strap assumed static out of reset, so a plain level sync is enough
   assign debug_mode = (r_q.sel_s[1] == djp_pkg::SEL_DEBUG);
   assign debug_serial_clock_rise = r_q.debug_serial_clock_s[1] & ~r_q.debug_serial_clock_prev;
   assign debug_serial_clock_fall = ~r_q.debug_serial_clock_s[1] & r_q.debug_serial_clock_prev;

   // reserved codes never reach the pins; the pins get "continue" instead
   assign pst_next = pst_is_legal(core_exec_status) ? core_exec_status
                                                    : djp_pkg::PST_CONTINUE;

   always_comb begin
      r_d = r_q;

      // two-flop synchronisers for strap, debug and gpio pins; tap pins go straight to the tap
      r_d.sel_s   = {r_q.sel_s[0], debug_jtag_select};
      r_d.debug_serial_clock_s = {r_q.debug_serial_clock_s[0], debug_serial_clock_raw};
      r_d.dsi_s   = {r_q.dsi_s[0], dsi_raw};
      r_d.breakpoint_request_n_s  = {r_q.breakpoint_request_n_s[0], breakpoint_request_n_raw_n};
      r_d.gpin_s1 = pad_in;
      r_d.gpin_s2 = r_q.gpin_s1;
      r_d.debug_serial_clock_prev = r_q.debug_serial_clock_s[1];

      // debug serial link; sampling needs clk at least twice debug_serial_clock
      r_d.cmd_valid = 1'b0;
      if (debug_mode) begin
         if (debug_serial_clock_rise) begin
            r_d.shift_in = {r_q.shift_in[14:0], r_q.dsi_s[1]};
            if (r_q.bit_cnt == djp_pkg::DS_LAST_BIT) begin
               r_d.bit_cnt   = '0;
               r_d.cmd_data  = {r_q.shift_in[14:0], r_q.dsi_s[1]};
               r_d.cmd_valid = 1'b1;
               r_d.shift_out = dbg_resp_data;
            end else begin
               r_d.bit_cnt = r_q.bit_cnt + 5'h01;
            end
         end
         if (debug_serial_clock_fall) begin
            r_d.debug_serial_out       = r_q.shift_out[15];
            r_d.shift_out = {r_q.shift_out[14:0], 1'b0};
         end
      end else begin
         r_d.bit_cnt = '0;
      end

      // breakpoint request is honoured only in debug mode
      r_d.hw_breakpoint_request_n = debug_mode & ~r_q.breakpoint_request_n_s[1];

      // status follows core execution state, one clk per update
      if ((r_q.pst_hold != 2'h0) && pst_is_long(r_q.pst)) begin
         r_d.pst_hold = r_q.pst_hold - 2'h1;
      end else begin
         r_d.pst = pst_next;
         r_d.pst_hold = pst_is_long(pst_next) ? djp_pkg::PST_HOLD_LOAD
                                              : 2'h0;
      end

      // debug nibble: captured data first, else breakpoint status
      r_d.ddata = capt_valid ? capt_data : breakpoint_request_n_status;

      r_d.assign_q = pin_assignment_reg;

      if (srst) begin
         r_d.bit_cnt   = '0;
         r_d.cmd_valid = 1'b0;
         r_d.cmd_data  = '0;
         r_d.shift_in  = '0;
         r_d.shift_out = '0;
         r_d.debug_serial_out       = 1'b1;
         r_d.hw_breakpoint_request_n   = 1'b0;
         r_d.pst       = djp_pkg::PST_CONTINUE;
         r_d.pst_hold  = 2'h0;
         r_d.ddata     = 4'h0;
         r_d.assign_q  = djp_pkg::PIN_ASSIGN_RST;
      end
   end

   always_ff @(posedge clk) begin
      r_q <= r_d;
   end

   // pad sharing: upper four carry status, lower four the debug nibble
   assign dbg_pads = {r_q.pst, r_q.ddata};

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (r_q.assign_q[i]) begin
            pad_out[i] = dbg_pads[i];
            // nothing drives in reset, even before the assignment clears
            pad_oe[i]  = ~srst;
         end else begin
            pad_out[i] = gpio_port_bits_out[i];
            // gpio never drives while the chip is in reset
            pad_oe[i]  = gpio_port_bits_oe[i] & ~srst;
         end
      end
   end

   assign gpio_port_bits_in = r_q.gpin_s2;
   assign dbg_cmd_data      = r_q.cmd_data;
   assign dbg_cmd_valid     = r_q.cmd_valid;
   assign hw_breakpoint     = r_q.hw_breakpoint_request_n;

endmodule

// File: design/djp_pkg.sv
// shared constants and types for the debug and test pin port
package djp_pkg;

   // strap levels
   localparam logic SEL_JTAG  = 1'b0;
   localparam logic SEL_DEBUG = 1'b1;

   // processor status codes
   localparam logic [3:0] PST_CONTINUE   = 4'h0;
   localparam logic [3:0] PST_BEGIN_INSN = 4'h1;
   localparam logic [3:0] PST_RSVD_2     = 4'h2;
   localparam logic [3:0] PST_USER_ENTRY = 4'h3;
   localparam logic [3:0] PST_PULSE      = 4'h4;
   localparam logic [3:0] PST_BRANCH     = 4'h5;
   localparam logic [3:0] PST_RSVD_6     = 4'h6;
   localparam logic [3:0] PST_EXC_RETURN = 4'h7;
   localparam logic [3:0] PST_EXCEPTION  = 4'hc;
   localparam logic [3:0] PST_EMU_ENTRY  = 4'hd;
   localparam logic [3:0] PST_STOPPED    = 4'he;
   localparam logic [3:0] PST_HALTED     = 4'hf;
   // least number of clocks a long-lived code stays on the pins
   localparam int         PST_HOLD_CYC   = 2;
   localparam logic [1:0] PST_HOLD_LOAD  = 2'(PST_HOLD_CYC - 1);

   // debug serial frame
   localparam int         DS_LEN      = 16;
   localparam logic [4:0] DS_LAST_BIT = 5'(DS_LEN - 1);

   // pin assignment after reset: all shared pins general purpose
   localparam logic [7:0] PIN_ASSIGN_RST = 8'h00;

   // jtag instruction register
   localparam int         IR_LEN     = 4;
   localparam logic [3:0] IR_EXTEST  = 4'h0;
   localparam logic [3:0] IR_SAMPLE  = 4'h2;
   localparam logic [3:0] IR_BYPASS  = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam int         BSR_LEN    = 8;

   typedef enum logic [15:0] {
      TAP_RESET      = 16'h0001,
      TAP_IDLE       = 16'h0002,
      TAP_SEL_DR     = 16'h0004,
      TAP_CAP_DR     = 16'h0008,
      TAP_SHIFT_DR   = 16'h0010,
      TAP_EXIT1_DR   = 16'h0020,
      TAP_PAUSE_DR   = 16'h0040,
      TAP_EXIT2_DR   = 16'h0080,
      TAP_UPD_DR     = 16'h0100,
      TAP_SEL_IR     = 16'h0200,
      TAP_CAP_IR     = 16'h0400,
      TAP_SHIFT_IR   = 16'h0800,
      TAP_EXIT1_IR   = 16'h1000,
      TAP_PAUSE_IR   = 16'h2000,
      TAP_EXIT2_IR   = 16'h4000,
      TAP_UPD_IR     = 16'h8000
   } djp_tap_state_type;

endpackage

// File: design/djp_tap.sv
// boundary-scan tap controller, runs on tck only
module djp_tap (
   // test clock and reset
   input  wire logic                         tck,
   input  wire logic                         trst_n,
   // serial test data
   input  wire logic                         tms,
   input  wire logic                         tdi,
   output logic                              tdo,
   output logic                              tdo_oe,
   // pad levels sampled into the boundary register
   input  wire logic [djp_pkg::BSR_LEN-1:0]  pad_in
);

   typedef struct packed {
      djp_pkg::djp_tap_state_type       state;
      logic [djp_pkg::IR_LEN-1:0]       ir;
      logic [djp_pkg::IR_LEN-1:0]       ir_sh;
      logic [djp_pkg::BSR_LEN-1:0]      bsr_sh;
      logic                             bypass;
   } djp_tap_regs_type;

   djp_tap_regs_type r_q;
   djp_tap_regs_type r_d;
   logic             tdo_q;
   logic             tdo_oe_q;
   logic             bsr_sel;
   logic             shift_bit;

   function automatic djp_pkg::djp_tap_state_type next_state(
      input djp_pkg::djp_tap_state_type s,
      input logic                       m);
      unique case (s)
         djp_pkg::TAP_RESET:    next_state = m ? djp_pkg::TAP_RESET
                                               : djp_pkg::TAP_IDLE;
         djp_pkg::TAP_IDLE:     next_state = m ? djp_pkg::TAP_SEL_DR
                                               : djp_pkg::TAP_IDLE;
         djp_pkg::TAP_SEL_DR:   next_state = m ? djp_pkg::TAP_SEL_IR
                                               : djp_pkg::TAP_CAP_DR;
         djp_pkg::TAP_CAP_DR:   next_state = m ? djp_pkg::TAP_EXIT1_DR
                                               : djp_pkg::TAP_SHIFT_DR;
         djp_pkg::TAP_SHIFT_DR: next_state = m ? djp_pkg::TAP_EXIT1_DR
                                               : djp_pkg::TAP_SHIFT_DR;
         djp_pkg::TAP_EXIT1_DR: next_state = m ? djp_pkg::TAP_UPD_DR
                                               : djp_pkg::TAP_PAUSE_DR;
         djp_pkg::TAP_PAUSE_DR: next_state = m ? djp_pkg::TAP_EXIT2_DR
                                               : djp_pkg::TAP_PAUSE_DR;
         djp_pkg::TAP_EXIT2_DR: next_state = m ? djp_pkg::TAP_UPD_DR
                                               : djp_pkg::TAP_SHIFT_DR;
         djp_pkg::TAP_UPD_DR:   next_state = m ? djp_pkg::TAP_SEL_DR
                                               : djp_pkg::TAP_IDLE;
         djp_pkg::TAP_SEL_IR:   next_state = m ? djp_pkg::TAP_RESET
                                               : djp_pkg::TAP_CAP_IR;
         djp_pkg::TAP_CAP_IR:   next_state = m ? djp_pkg::TAP_EXIT1_IR
                                               : djp_pkg::TAP_SHIFT_IR;
         djp_pkg::TAP_SHIFT_IR: next_state = m ? djp_pkg::TAP_EXIT1_IR
                                               : djp_pkg::TAP_SHIFT_IR;
         djp_pkg::TAP_EXIT1_IR: next_state = m ? djp_pkg::TAP_UPD_IR
                                               : djp_pkg::TAP_PAUSE_IR;
         djp_pkg::TAP_PAUSE_IR: next_state = m ? djp_pkg::TAP_EXIT2_IR
                                               : djp_pkg::TAP_PAUSE_IR;
         djp_pkg::TAP_EXIT2_IR: next_state = m ? djp_pkg::TAP_UPD_IR
                                               : djp_pkg::TAP_SHIFT_IR;
         djp_pkg::TAP_UPD_IR:   next_state = m ? djp_pkg::TAP_SEL_DR
                                               : djp_pkg::TAP_IDLE;
         default:               next_state = djp_pkg::TAP_RESET;
      endcase
   endfunction

   assign bsr_sel = (r_q.ir == djp_pkg::IR_EXTEST) ||
                    (r_q.ir == djp_pkg::IR_SAMPLE);

   always_comb begin
      r_d = r_q;
      r_d.state = next_state(r_q.state, tms);
      unique case (r_q.state)
         djp_pkg::TAP_RESET:    r_d.ir = djp_pkg::IR_BYPASS;
         djp_pkg::TAP_CAP_DR: begin
            r_d.bypass = 1'b0;
            r_d.bsr_sh = pad_in;
         end
         djp_pkg::TAP_SHIFT_DR: begin
            if (bsr_sel) begin
               r_d.bsr_sh = {tdi, r_q.bsr_sh[djp_pkg::BSR_LEN-1:1]};
            end else begin
               r_d.bypass = tdi;
            end
         end
         djp_pkg::TAP_CAP_IR:   r_d.ir_sh = djp_pkg::IR_CAPTURE;
         djp_pkg::TAP_SHIFT_IR:
            r_d.ir_sh = {tdi, r_q.ir_sh[djp_pkg::IR_LEN-1:1]};
         djp_pkg::TAP_UPD_IR:   r_d.ir = r_q.ir_sh;
         default: ;
      endcase
   end

   // state survives any pause of tck; only trst clears it
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         r_q.state  <= djp_pkg::TAP_RESET;
         r_q.ir     <= djp_pkg::IR_BYPASS;
         r_q.ir_sh  <= djp_pkg::IR_CAPTURE;
         r_q.bsr_sh <= '0;
         r_q.bypass <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign shift_bit = (r_q.state == djp_pkg::TAP_SHIFT_IR) ? r_q.ir_sh[0]
                    : (bsr_sel ? r_q.bsr_sh[0] : r_q.bypass);

   // output stage launches on the falling edge
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q    <= shift_bit;
         tdo_oe_q <= (r_q.state == djp_pkg::TAP_SHIFT_DR) ||
                     (r_q.state == djp_pkg::TAP_SHIFT_IR);
      end
   end

   assign tdo    = tdo_q;
   assign tdo_oe = tdo_oe_q;

endmodule

// File: verif/djp_port_asserts.sv
// concurrent checks on the ports of the debug and test pin port
module djp_port_asserts (
   // clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // strap and shared pins
   input wire logic       debug_jtag_select,
   input wire logic       pin_trst_debug_serial_clock,
   input wire logic       pin_tms_breakpoint_request_n,
   input wire logic       pin_tdo_dso_oe,
   // pads
   input wire logic [7:0] pad_in,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   input wire logic [7:0] pin_assignment_reg,
   input wire logic [7:0] gpio_port_bits_in,
   // core side
   input wire logic [3:0] core_exec_status,
   input wire logic [3:0] capt_data,
   input wire logic       capt_valid,
   input wire logic [3:0] breakpoint_request_n_status,
   input wire logic       dbg_cmd_valid,
   input wire logic       hw_breakpoint
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] sel_q;
   logic       nib_q;

   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);

   // pad mux follows the assignment one clock late
   always_ff @(posedge clk) begin
      sel_q <= {sel_q[0], !srst && pin_assignment_reg[7:4] == 4'hf};
      nib_q <= !srst && pin_assignment_reg[3:0] == 4'hf;
   end

   sequence long_new;
      sel_q[1] && sel_q[0] && pad_out[7:6] == 2'b11
         && !$stable(pad_out[7:4]);
   endsequence

   chk_status_legal: assert property (sel_q[0] |-> pad_oe[7:4] == 4'hf &&
      !(pad_out[7:4] inside {4'h2, 4'h6, [4'h8:4'hb]}))
      else $error("reserved or undriven status code");
   chk_status_follow: assert property (sel_q[0]
      && $past(core_exec_status, 2) == $past(core_exec_status)
      && $past(core_exec_status) inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7}
      |-> pad_out[7:4] == $past(core_exec_status))
      else $error("status does not follow core");
   chk_status_hold: assert property (long_new ##1 sel_q[0]
      |-> $stable(pad_out[7:4]))
      else $error("long status code shown one clock only");
   chk_nibble_src: assert property (nib_q |-> pad_out[3:0] ==
      ($past(capt_valid) ? $past(capt_data) : $past(breakpoint_request_n_status)))
      else $error("debug nibble wrong source");
   chk_gpio_sync: assert property (!$past(srst) && !$past(srst, 2)
      |-> gpio_port_bits_in == $past(pad_in, 2))
      else $error("gpio input path wrong");
   chk_breakpoint_request_n_halt: assert property (
      (debug_jtag_select && !pin_tms_breakpoint_request_n) [*4] |-> hw_breakpoint)
      else $error("breakpoint request ignored");
   chk_breakpoint_request_n_idle: assert property (
      (!debug_jtag_select || pin_tms_breakpoint_request_n) [*4] |-> !hw_breakpoint)
      else $error("breakpoint without request");
   chk_cmd_pulse: assert property (dbg_cmd_valid |=> !dbg_cmd_valid)
      else $error("command valid longer than one clock");
   chk_trst_release: assert property (
      !debug_jtag_select && !pin_trst_debug_serial_clock |-> !pin_tdo_dso_oe)
      else $error("tdo driven during test reset");
   chk_dso_drive: assert property (debug_jtag_select |-> pin_tdo_dso_oe)
      else $error("serial out not driven in debug mode");
endmodule

// File: verif/djp_host_model.sv
// far-side model: debug host and boundary-scan tester
module djp_host_model (
   // pins toward the port
   output logic      tck,
   output logic      pin_c,
   output logic      pin_m,
   output logic      pin_d,
   input  wire logic debug_serial_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle at the pull-up level; test clock stands still low
   initial begin
      tck = 1'b0;
      pin_c = 1'b1;
      pin_m = 1'b1;
      pin_d = 1'b1;
   end

   task automatic set_pins(input logic c, input logic m);
      pin_c = c;
      pin_m = m;
   endtask

   // msb first; returns the response of the previous frame
   task automatic frame(input logic [15:0] cmd, output logic [15:0] rsp);
      for (int i = 15; i >= 0; i--) begin
         pin_d = cmd[i];
         pin_c = 1'b0;
         #240; // six clocks a phase, below half clk
         rsp[i] = debug_serial_out;
         pin_c = 1'b1;
         #240;
      end
      pin_d = 1'b1;
   endtask

   // tdo taken just before each rising tck
   task automatic jseq(input logic [15:0] t, input logic [15:0] d,
                       input int n, output logic [15:0] tdo);
      for (int i = 0; i < n; i++) begin
         pin_m = t[i];
         pin_d = d[i];
         #80;
         tdo[i] = debug_serial_out;
         tck = 1'b1;
         #80;
         tck = 1'b0;
      end
      pin_d = 1'b1;
      // let time pass so a following call never re-drives pins at once
      #80;
   endtask
endmodule

// File: verif/tb_djp_port.sv
// self-checking bench for the debug and test pin port
module tb_djp_port;
   timeunit 1ns;
   timeprecision 1ps;

   // boundary pattern: bits 0 and 1 set so bypass shows apart
   localparam logic [7:0] PAD_EXT = 8'h5b;

   logic        clk, srst, debug_jtag_select, tck;
   logic        pin_trst_debug_serial_clock, pin_tms_breakpoint_request_n, pin_tdi_dsi;
   logic        pin_tdo_dso_out, pin_tdo_dso_oe, capt_valid;
   logic        dbg_cmd_valid, hw_breakpoint;
   logic [7:0]  pad_out, pad_oe, pin_assignment_reg, gpio_port_bits_in;
   logic [7:0]  gpio_port_bits_out, gpio_port_bits_oe;
   logic [3:0]  core_exec_status, capt_data, breakpoint_request_n_status;
   logic [15:0] dbg_cmd_data, dbg_resp_data, r;
   wire  [7:0]  pad_in = (pad_oe & pad_out) | (~pad_oe & PAD_EXT);
   wire         debug_serial_out = pin_tdo_dso_oe ? pin_tdo_dso_out : 1'bz;
   int          failures = 0;
   int          checked = 0;
   int          pulses = 0;

   djp_port i_djp_port (.clk, .srst, .tck, .debug_jtag_select,
      .pin_trst_debug_serial_clock, .pin_tms_breakpoint_request_n, .pin_tdi_dsi, .pin_tdo_dso_out,
      .pin_tdo_dso_oe, .pad_in, .pad_out, .pad_oe, .pin_assignment_reg,
      .gpio_port_bits_out, .gpio_port_bits_oe, .gpio_port_bits_in,
      .core_exec_status, .capt_data, .capt_valid, .breakpoint_request_n_status,
      .dbg_cmd_data, .dbg_cmd_valid, .dbg_resp_data, .hw_breakpoint);
   djp_host_model i_djp_host_model (.tck(tck), .pin_c(pin_trst_debug_serial_clock),
      .pin_m(pin_tms_breakpoint_request_n), .pin_d(pin_tdi_dsi), .debug_serial_out(debug_serial_out));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dbg_cmd_valid === 1'b1) pulses++;
   end

   task automatic check_val(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict;
      if (failures == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // strap moves only inside reset; three edges flush the synchronisers
   task automatic do_reset(input logic sel);
      srst = 1'b1;
      debug_jtag_select = sel;
      pin_assignment_reg = 8'hff;
      gpio_port_bits_oe = 8'hff;
      cyc(1);
      check_val("pad_oe in reset", 16'h0, 16'(pad_oe));
      cyc(2);
      srst = 1'b0;
      pulses = 0;
   endtask

   task automatic t_status;
      logic [3:0] e;
      pin_assignment_reg = 8'hff;
      for (int c = 0; c < 16; c++) begin
         core_exec_status = 4'(c);
         cyc(3);
         e = (c == 2 || c == 6 || c[3:2] == 2'b10) ? 4'h0 : 4'(c);
         check_val("status", 16'(e), 16'(pad_out[7:4]));
      end
      core_exec_status = 4'hc;
      cyc(1);
      core_exec_status = 4'h1;
      cyc(1);
      check_val("status held", 16'hc, 16'(pad_out[7:4]));
      cyc(1);
      check_val("status next", 16'h1, 16'(pad_out[7:4]));
      capt_valid = 1'b1;
      capt_data = 4'h9;
      breakpoint_request_n_status = 4'h6;
      cyc(2);
      check_val("nibble data", 16'h9, 16'(pad_out[3:0]));
      capt_valid = 1'b0;
      cyc(2);
      check_val("nibble breakpoint_request_n", 16'h6, 16'(pad_out[3:0]));
   endtask

   task automatic t_gpio;
      pin_assignment_reg = 8'h00;
      gpio_port_bits_out = 8'h3c;
      gpio_port_bits_oe = 8'hf0;
      cyc(3);
      check_val("gpio oe", 16'hf0, 16'(pad_oe));
      check_val("gpio out", 16'h3, 16'(pad_out[7:4]));
      check_val("gpio in", {8'h0, 4'h3, PAD_EXT[3:0]},
                16'(gpio_port_bits_in));
   endtask

   task automatic t_debug;
      do_reset(1'b1);
      dbg_resp_data = 16'h9b6d;
      i_djp_host_model.frame(16'hc3a5, r);
      cyc(8);
      check_val("cmd one", 16'hc3a5, dbg_cmd_data);
      i_djp_host_model.frame(16'h0ff0, r);
      check_val("response", 16'h9b6d, r);
      cyc(8);
      check_val("cmd two", 16'h0ff0, dbg_cmd_data);
      check_val("cmd pulses", 16'h2, 16'(pulses));
      i_djp_host_model.set_pins(1'b1, 1'b0);
      cyc(6);
      check_val("breakpoint", 16'h1, 16'(hw_breakpoint));
      i_djp_host_model.set_pins(1'b1, 1'b1);
      cyc(6);
      check_val("breakpoint off", 16'h0, 16'(hw_breakpoint));
   endtask

   task automatic t_jtag;
      do_reset(1'b0);
      pin_assignment_reg = 8'h00;
      gpio_port_bits_oe = 8'h00;
      i_djp_host_model.set_pins(1'b0, 1'b1);
      cyc(2);
      check_val("tdo oe trst", 16'h0, 16'(pin_tdo_dso_oe));
      i_djp_host_model.set_pins(1'b1, 1'b1);
      // tms stays high across the trst release before the first scan
      cyc(1);
      i_djp_host_model.jseq(16'h0062, 16'h0010, 8, r);
      check_val("bypass dr", 16'h0020, r & 16'h0030);
      i_djp_host_model.jseq(16'h0183, 16'h0020, 10, r);
      check_val("ir capture", 16'h0010, r & 16'h00f0);
      i_djp_host_model.jseq(16'h97f1, 16'h0000, 16, r);
      check_val("sample dr", 16'h0018, r & 16'h8018);
   endtask

   initial begin
      srst = 1'b1;
      debug_jtag_select = 1'b1;
      pin_assignment_reg = 8'h00;
      gpio_port_bits_out = 8'h00;
      gpio_port_bits_oe = 8'hff;
      core_exec_status = 4'h0;
      capt_data = 4'h0;
      capt_valid = 1'b0;
      breakpoint_request_n_status = 4'h0;
      dbg_resp_data = 16'h0;
      cyc(2);
      srst = 1'b0;
      t_status;
      t_gpio;
      t_debug;
      t_jtag;
      print_verdict;
   end

   // whole run needs well under 100 us
   initial begin
      #500_000;
      failures++;
      print_verdict;
   end
endmodule

bind djp_port djp_port_asserts i_djp_port_asserts (.clk, .srst,
   .debug_jtag_select, .pin_trst_debug_serial_clock, .pin_tms_breakpoint_request_n, .pin_tdo_dso_oe,
   .pad_in, .pad_out, .pad_oe, .pin_assignment_reg, .gpio_port_bits_in,
   .core_exec_status, .capt_data, .capt_valid, .breakpoint_request_n_status,
   .dbg_cmd_valid, .hw_breakpoint);
